//--- hw/serial_rx_pkg.sv
// Shared constants, types and code tables for the serial link receiver.
package serial_rx_pkg;
	localparam int CODE_BITS = 10;
	typedef logic [CODE_BITS-1:0] code_t;
	localparam code_t K285_NEG = 10'h0fa;
	localparam code_t K285_POS = 10'h305;
	localparam logic [5:0] K28_NEG6 = 6'h0f;
	localparam logic [5:0] K28_POS6 = 6'h30;
	localparam logic [4:0] K28_X = 5'h1c;
	localparam logic [3:0] A7_NEG = 4'h7;
	localparam logic [3:0] A7_POS = 4'h8;
	localparam logic [7:0] NO_DATA_BYTE = 8'he0;
	localparam logic [5:0] ENC6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
		6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
	localparam logic [3:0] ENC4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
	localparam logic [3:0] BIT_LAST = 4'h9;
	localparam logic [3:0] CLK_HIGH_BITS = 4'h5;
	localparam int REFRAME_LIMIT = 2048;
	localparam int MULTI_SPAN_CHARS = 4;
	localparam int MCLK_MHZ = 25;
	localparam int REF_BIT_NS = 320;
	localparam int REF_BIT_CYCLES = (REF_BIT_NS * MCLK_MHZ + 999) / 1000;
	localparam int LOOP_LIMIT_CYCLES = 1;
	localparam int IDLE_BITS = 20;
	localparam int IDLE_CYCLES = IDLE_BITS * REF_BIT_CYCLES;
	localparam int SYNC_W = 7;
	localparam logic [5:0] GAP_RESET = 6'h3f;
	typedef struct packed {
		logic        strobe;
		logic        sc;
		logic        viol;
		logic        fok;
		logic [7:0]  byte_v;
		code_t       raw;
	} rx_word_s;
	localparam int WORD_W = $bits(rx_word_s);
endpackage : serial_rx_pkg

//--- hw/rx_word_if.sv
// Valid/ready carrier for received words from the framer into its buffer and from the buffer to the output stage.
`timescale 1ns/1ps
interface rx_word_if #(parameter int W = 22);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : rx_word_if

//--- hw/rx_word_buf.sv
// Small FIFO that holds received words while the host stalls.
`timescale 1ns/1ps
module rx_word_buf #(
	parameter int W     = serial_rx_pkg::WORD_W,
	parameter int DEPTH = 2
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	rx_word_if.snk   wr,
	rx_word_if.src   rd
);
	import serial_rx_pkg::*;
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : next_ptr

	assign wr.ready = (cnt_r != FULL);
	assign rd.valid = (cnt_r != '0);
	assign rd.data  = mem_r[rp_r];
	assign push     = clk_en & wr.valid & wr.ready;
	assign pop      = clk_en & rd.valid & rd.ready;

	always_ff @(posedge mclk) begin
		if (push) begin
			mem_r[wp_r] <= wr.data;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= next_ptr(wp_r);
			end
			if (pop) begin
				rp_r <= next_ptr(rp_r);
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule : rx_word_buf

//--- hw/serial_rx_link.sv
// Serial link receiver: line select, bit clock fallback, byte framer, decoder and output stage.
//
// Contract
// - Select line low takes data from line B.
// - Loopback input low forces loopback output low.
// - Encoded no-data gives violation and C0.7.
// - Bypass no-data drives raw code low.
// - No data: bit clock tracks reference rate.
// - Stream switch needs K28.5, or two within four.
// - At offset limit, recenter on reference first.
// - Out of lock, stay within offset limits.
// - Bypass clean break: reference clock, strobe high.
// - Encoded clean break: strobe once per byte.
// - Encoded break shows C0.7, special, violation.
// - Bypass noise strobes only on K28.5 pattern.
// - Framer only with reframe high; else aligned.
// - After 2048 bytes reframe, need spaced pair.
// - Bypass strobe pulses per detected K28.5.
`timescale 1ns/1ps
module serial_rx_link (
	input  wire logic           mclk,
	input  wire logic           sys_rst,
	input  wire logic           clk_en,
	input  wire logic           line_a_in,
	input  wire logic           line_b_in,
	input  wire logic           line_select_in,
	input  wire logic           link_clk_in,
	input  wire logic           loop_serial_in,
	input  wire logic           reframe_enable,
	input  wire logic           bypass_mode,
	input  wire logic           host_ready,
	output logic                recovered_clock,
	output logic                char_strobe_n,
	output logic [7:0]          decoded_byte_out,
	output logic                special_char_flag,
	output logic                violation_flag,
	output serial_rx_pkg::code_t raw_code_out,
	output logic                data_valid,
	output logic                frame_ok,
	output logic                loop_serial_out,
	output logic                word_lost
);
	import serial_rx_pkg::*;
	localparam logic [7:0] REF_P   = 8'(REF_BIT_CYCLES);
	localparam logic [7:0] LIM_P   = 8'(LOOP_LIMIT_CYCLES);
	localparam logic [7:0] IDLE_P  = 8'(IDLE_CYCLES);
	localparam logic [11:0] AGE_P  = 12'(REFRAME_LIMIT);
	localparam logic [5:0] SPAN_P  = 6'(MULTI_SPAN_CHARS * CODE_BITS);

	logic [SYNC_W-1:0] sync1_r, sync2_r;
	logic       a_s, b_s, sel_s, link_s, loop_s, bypass_s, reframe_s;
	logic       link_d_r, data_d_r, sel_d_r;
	logic       data_bit, link_edge, data_edge, no_data, bit_tick, meas_ok;
	logic [7:0] idle_cnt_r, meas_cnt_r, loop_period_r, ph_cnt_r;
	code_t      shreg_r, sh_nxt;
	logic [3:0] bit_cnt_r;
	logic [5:0] gap_r;
	logic [11:0] age_r;
	logic       k_seen, multi, gap_ok, realign, aligned_k, word_done, frame_ok_r;
	rx_word_s   w;
	rx_word_s   head;
	logic       pop;
	logic [12:0] dec;
	logic       rclk_r, strobe_n_r, sc_r, viol_r, valid_r, loop_r, lost_r;
	logic [7:0] byte_r;
	code_t      raw_r;

	rx_word_if #(.W(WORD_W)) push_if ();
	rx_word_if #(.W(WORD_W)) pop_if ();

	function automatic logic [5:0] dec6(input logic [5:0] c);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < 32; i++) begin
			if (c == ENC6[i] || (c == ~ENC6[i] && ($countones(ENC6[i]) != 3 || i == 7))) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction : dec6

	function automatic logic [3:0] dec4(input logic [3:0] c);
		logic [3:0] r;
		r = (c == A7_NEG || c == A7_POS) ? 4'hf : 4'h0;
		for (int i = 0; i < 8; i++) begin
			if (c == ENC4[i] || (c == ~ENC4[i] && ($countones(ENC4[i]) != 2 || i == 3))) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction : dec4

	// Returns special flag, violation flag and the decoded byte; disparity is not tracked.
	function automatic logic [9:0] decode_word(input code_t c);
		logic       k6;
		logic [5:0] d6;
		logic [3:0] d4;
		k6 = (c[9:4] == K28_NEG6) || (c[9:4] == K28_POS6);
		d6 = dec6(c[9:4]);
		d4 = dec4((c[9:4] == K28_POS6) ? ~c[3:0] : c[3:0]);
		return {k6, !(k6 || d6[5]) || !d4[3], d4[2:0], k6 ? K28_X : d6[4:0]};
	endfunction : decode_word

	function automatic logic is_k285(input code_t c);
		return (c == K285_NEG) || (c == K285_POS);
	endfunction : is_k285

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else if (clk_en) begin
			sync1_r <= {reframe_enable, bypass_mode, loop_serial_in, link_clk_in, line_select_in, line_b_in, line_a_in};
			sync2_r <= sync1_r;
		end
	end
	assign {reframe_s, bypass_s, loop_s, link_s, sel_s, b_s, a_s} = sync2_r;

	assign data_bit  = sel_s ? a_s : b_s;
	assign link_edge = clk_en & link_s & !link_d_r;
	assign data_edge = clk_en & (data_bit != data_d_r);
	assign no_data   = (idle_cnt_r == IDLE_P);
	assign meas_ok   = (meas_cnt_r >= REF_P - LIM_P) && (meas_cnt_r <= REF_P + LIM_P);
	// Without data the loop free-runs on the reference period REF_P, which is always inside the limits.
	assign bit_tick  = clk_en & (no_data ? (ph_cnt_r >= loop_period_r - 8'd1) : link_edge);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			link_d_r   <= 1'b0;
			data_d_r   <= 1'b0;
			sel_d_r    <= 1'b0;
			idle_cnt_r <= IDLE_P;
		end else if (clk_en) begin
			link_d_r <= link_s;
			data_d_r <= data_bit;
			sel_d_r  <= sel_s;
			if (data_edge) begin
				idle_cnt_r <= '0;
			end else if (!no_data) begin
				idle_cnt_r <= idle_cnt_r + 8'd1;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			meas_cnt_r    <= '0;
			loop_period_r <= REF_P;
			ph_cnt_r      <= '0;
		end else if (clk_en) begin
			if (link_edge) begin
				meas_cnt_r <= 8'd1;
			end else if (meas_cnt_r != 8'hff) begin
				meas_cnt_r <= meas_cnt_r + 8'd1;
			end
			if (no_data) begin
				loop_period_r <= REF_P;
			end else if (link_edge) begin
				loop_period_r <= meas_ok ? meas_cnt_r : REF_P;
			end
			ph_cnt_r <= bit_tick ? 8'd0 : ph_cnt_r + 8'd1;
		end
	end

	assign sh_nxt    = {shreg_r[8:0], data_bit};
	assign k_seen    = is_k285(sh_nxt);
	assign multi     = (age_r > AGE_P);
	assign gap_ok    = (gap_r < SPAN_P) && ((6'(gap_r + 6'd1) % 6'd10) == 6'd0);
	assign realign   = bit_tick & reframe_s & k_seen & (!multi | gap_ok);
	assign aligned_k = bit_tick & (bit_cnt_r == BIT_LAST) & k_seen;
	assign word_done = bit_tick & ((bit_cnt_r == BIT_LAST) | realign);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			shreg_r   <= '0;
			bit_cnt_r <= '0;
			gap_r     <= GAP_RESET;
		end else if (bit_tick) begin
			shreg_r   <= sh_nxt;
			bit_cnt_r <= word_done ? 4'd0 : bit_cnt_r + 4'd1;
			if (k_seen) begin
				gap_r <= '0;
			end else if (gap_r != GAP_RESET) begin
				gap_r <= gap_r + 6'd1;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			age_r      <= '0;
			frame_ok_r <= 1'b0;
		end else if (clk_en) begin
			if (!reframe_s) begin
				age_r <= '0;
			end else if (word_done && !multi) begin
				age_r <= age_r + 12'd1;
			end
			if (no_data || sel_s != sel_d_r) begin
				frame_ok_r <= 1'b0;
			end else if (realign || (aligned_k && !reframe_s)) begin
				frame_ok_r <= 1'b1;
			end
		end
	end

	always_comb begin
		dec      = {3'b000, decode_word(sh_nxt)};
		w.raw    = no_data ? '0 : sh_nxt;
		w.fok    = frame_ok_r;
		w.sc     = no_data ? 1'b1 : dec[9];
		w.viol   = no_data ? 1'b1 : dec[8];
		w.byte_v = no_data ? NO_DATA_BYTE : dec[7:0];
		w.strobe = bypass_s ? (k_seen & !no_data) : 1'b1;
	end

	assign push_if.valid = word_done;
	assign push_if.data  = w;
	assign head          = rx_word_s'(pop_if.data);
	assign pop_if.ready  = host_ready;
	assign pop           = clk_en & pop_if.valid & host_ready;

	rx_word_buf #(.W(WORD_W), .DEPTH(2)) u_buf (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.wr      (push_if.snk),
		.rd      (pop_if.src)
	);

	// Word fields change only when the host takes a word, so a stall holds the last word steady.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rclk_r     <= 1'b0;
			strobe_n_r <= 1'b1;
			byte_r     <= '0;
			sc_r       <= 1'b0;
			viol_r     <= 1'b0;
			raw_r      <= '0;
			valid_r    <= 1'b0;
			loop_r     <= 1'b0;
			lost_r     <= 1'b0;
		end else if (clk_en) begin
			rclk_r     <= (bit_cnt_r < CLK_HIGH_BITS);
			strobe_n_r <= !(pop && head.strobe);
			valid_r    <= pop && head.fok;
			loop_r     <= loop_s;
			lost_r     <= word_done && !push_if.ready;
			if (pop) begin
				byte_r <= head.byte_v;
				sc_r   <= head.sc;
				viol_r <= head.viol;
				raw_r  <= head.raw;
			end
		end
	end

	assign recovered_clock   = rclk_r;
	assign char_strobe_n     = strobe_n_r;
	assign decoded_byte_out  = byte_r;
	assign special_char_flag = sc_r;
	assign violation_flag    = viol_r;
	assign raw_code_out      = raw_r;
	assign data_valid        = valid_r;
	assign frame_ok          = frame_ok_r;
	assign loop_serial_out   = loop_r;
	assign word_lost         = lost_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	chk_line_b_pick: assert property (!sel_s && bit_tick |=> shreg_r[0] == $past(b_s)) else $error("line B not used");
	chk_loop_low: assert property (clk_en && !loop_s |=> !loop_serial_out) else $error("loopback not low");
	chk_nodata_enc: assert property (word_done && no_data && !bypass_s |-> w.byte_v == 8'he0 && w.viol && w.sc)
		else $error("no-data word wrong");
	chk_nodata_raw: assert property (word_done && no_data && bypass_s |-> w.raw == 10'h000 && !w.strobe)
		else $error("bypass no-data word wrong");
	chk_ref_period: assert property ((no_data && $past(no_data) && bit_tick) ##1 (no_data && clk_en && !bit_tick)[*7]
		##1 (no_data && clk_en) |-> bit_tick) else $error("reference bit period wrong");
	chk_loop_bounds: assert property (loop_period_r >= REF_P - LIM_P && loop_period_r <= REF_P + LIM_P)
		else $error("loop period out of limits");
	chk_recenter: assert property (link_edge && !no_data && !meas_ok |=> loop_period_r == REF_P)
		else $error("loop not recentered");
	chk_enc_strobe: assert property (word_done && !bypass_s |-> push_if.data[WORD_W-1]) else $error("encoded word without strobe");
	chk_single_align: assert property (bit_tick && reframe_s && !multi && k_seen |-> realign ##1 bit_cnt_r == 4'd0)
		else $error("single K28.5 did not align");
	chk_multi_pair: assert property (bit_tick && multi && k_seen && !gap_ok |-> !realign) else $error("lone K28.5 realigned");
	chk_no_framer: assert property (!reframe_s |-> !realign) else $error("framer active with reframe low");
	chk_bypass_k: assert property (word_done && bypass_s && k_seen && !no_data |-> w.strobe) else $error("K28.5 not strobed");
	chk_strobe_cause: assert property ($fell(char_strobe_n) |-> $past(pop && head.strobe)) else $error("stray strobe");
	chk_frame_clear: assert property (clk_en && no_data |=> !frame_ok ##1 !data_valid) else $error("frame not dropped");

	cov_multi_align: cover property (multi && realign);
	cov_nodata_enc: cover property (word_done && no_data && !bypass_s);
	cov_stall_full: cover property (word_done && !push_if.ready);
	cov_valid_out: cover property (data_valid && !char_strobe_n);
endmodule : serial_rx_link

//--- tb/serial_tx_model.sv
// Remote serial transmitter model that sends 10-bit code words with its own bit clock.
`timescale 1ns/1ps
module serial_tx_model
	import serial_rx_pkg::*;
#(
	parameter int BIT_NS = 320
) (
	output logic link_clk,
	output logic line_out
);
	initial begin
		link_clk = 1'b0;
		line_out = 1'b0;
	end

	// The bit clock stands still between frames and the line keeps its last level, as in a clean break.
	// Bits leave first-bit-first and change while the clock is low, so every rising edge sees a settled bit.
	task automatic send(input code_t q[$]);
		#7;
		foreach (q[w]) begin
			for (int b = CODE_BITS - 1; b >= 0; b--) begin
				line_out = q[w][b];
				#(BIT_NS / 2) link_clk = 1'b1;
				#(BIT_NS / 2) link_clk = 1'b0;
			end
		end
	endtask : send
endmodule : serial_tx_model

//--- tb/serial_rx_link_tb.sv
// Self-checking bench for the serial link receiver.
`timescale 1ns/1ps
module serial_rx_link_tb;
	import serial_rx_pkg::*;
	localparam code_t D21_5 = 10'h2aa;
	localparam code_t D10_2 = 10'h155;
	logic       mclk            = 1'b0;
	logic       sys_rst         = 1'b1;
	logic       line_a_in       = 1'b0;
	logic       line_select_in  = 1'b0;
	logic       loop_serial_in  = 1'b0;
	logic       reframe_enable  = 1'b1;
	logic       bypass_mode     = 1'b0;
	logic       host_ready      = 1'b1;
	logic       clk_en          = 1'b1;
	logic       line_b_in;
	logic       link_clk_in;
	logic       recovered_clock;
	logic       char_strobe_n;
	logic       special_char_flag;
	logic       violation_flag;
	logic       data_valid;
	logic       frame_ok;
	logic       loop_serial_out;
	logic       word_lost;
	logic [7:0] decoded_byte_out;
	code_t      raw_code_out;
	code_t      last_raw;
	logic       rclk_d          = 1'b0;
	logic [9:0] got_q[$];
	int         fails           = 0;
	int         n_tests         = 0;
	int         n_strobe        = 0;
	int         n_rclk          = 0;
	int         n_lost          = 0;

	always #20 mclk = ~mclk;

	serial_rx_link DUT (
		.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .line_a_in(line_a_in), .line_b_in(line_b_in),
		.line_select_in(line_select_in), .link_clk_in(link_clk_in), .loop_serial_in(loop_serial_in),
		.reframe_enable(reframe_enable), .bypass_mode(bypass_mode), .host_ready(host_ready),
		.recovered_clock(recovered_clock), .char_strobe_n(char_strobe_n), .decoded_byte_out(decoded_byte_out),
		.special_char_flag(special_char_flag), .violation_flag(violation_flag), .raw_code_out(raw_code_out),
		.data_valid(data_valid), .frame_ok(frame_ok), .loop_serial_out(loop_serial_out), .word_lost(word_lost)
	);

	serial_tx_model tx (
		.link_clk(link_clk_in),
		.line_out(line_b_in)
	);

	always @(posedge mclk) begin
		if (char_strobe_n === 1'b0) begin
			n_strobe++;
			last_raw = raw_code_out;
		end
		if (recovered_clock === 1'b1 && rclk_d === 1'b0)
			n_rclk++;
		rclk_d = recovered_clock;
		if (word_lost === 1'b1)
			n_lost++;
		if (data_valid === 1'b1)
			got_q.push_back({special_char_flag, violation_flag, decoded_byte_out});
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	task automatic window(input int n);
		n_strobe = 0;
		n_rclk = 0;
		n_lost = 0;
		cyc(n);
	endtask : window

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	initial begin
		fork
			begin
				cyc(20000);
				fails++;
				print_verdict();
			end
		join_none
		cyc(3);
		sys_rst = 1'b0;
		cyc(4);
		check("loop_low", loop_serial_out, 0);
		loop_serial_in = 1'b1;
		cyc(4);
		check("loop_high", loop_serial_out, 1);
		// Encoded stream on line B: the first comma may be cut short, the second one aligns.
		tx.send('{K285_NEG, K285_NEG, D21_5, D10_2});
		cyc(40);
		check("frame_ok", frame_ok, 1);
		check("word_a", got_q[$-1], {2'b00, 8'hb5});
		check("word_b", got_q[$], {2'b00, 8'h4a});
		// Switching to the flat line A drops framing and later counts as no data.
		line_select_in = 1'b1;
		cyc(6);
		check("fok_switch", frame_ok, 0);
		cyc(300);
		window(800);
		check("idle_strobes", n_strobe, 10);
		check("rclk_ref", n_rclk, 10);
		check("idle_word", {special_char_flag, violation_flag, decoded_byte_out}, {2'b11, 8'he0});
		check("fok_idle", frame_ok, 0);
		// A low clock enable must stop the fallback bit clock along with all other state.
		clk_en = 1'b0;
		window(200);
		check("freeze_rclk", n_rclk, 0);
		clk_en = 1'b1;
		window(160);
		check("resume_rclk", n_rclk, 2);
		host_ready = 1'b0;
		window(400);
		check("lost", n_lost >= 2, 1);
		n_strobe = 0;
		host_ready = 1'b1;
		cyc(4);
		check("drain", n_strobe, 2);
		bypass_mode = 1'b1;
		reframe_enable = 1'b0;
		cyc(100);
		window(400);
		check("byp_strobe", n_strobe, 0);
		check("byp_raw", raw_code_out, 0);
		line_select_in = 1'b0;
		reframe_enable = 1'b1;
		cyc(10);
		n_strobe = 0;
		tx.send('{K285_NEG, K285_NEG, D21_5, K285_POS, D10_2});
		cyc(40);
		check("byp_k_raw", last_raw, K285_POS);
		check("byp_k_cnt", n_strobe >= 2, 1);
		// With the framer off, a comma straddling two words is plain data and gives no strobe.
		reframe_enable = 1'b0;
		cyc(4);
		n_strobe = 0;
		tx.send('{10'h2a7, 10'h355});
		cyc(20);
		check("misalign_strobe", n_strobe, 0);
		check("misalign_raw", raw_code_out, 10'h355);
		print_verdict();
	end
endmodule : serial_rx_link_tb
